/* File: src/kpil_top.sv */
// Purpose: Keypad pin interrupt latch core.
// Assumes: Controls are plain ports from a register file outside.
// Notes: Pending flag and CPU request are registered.
`timescale 1ns/1ps
`include "kpil_params.svh"
module kpil_top #(
  parameter int N = `KPIL_NUM_PINS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Key pins
  input wire logic [N-1:0] key_pin_i,
  output logic [N-1:0] key_pullup_en_o,
  output logic [N-1:0] key_force_input_o,
  output logic [N-1:0] key_read_ok_o,
  // Port direction
  input wire logic [N-1:0] port_a_direction_bits_i,
  // Control writes
  input wire logic ctrl_we_i,
  input wire logic [N-1:0] pin_irq_enable_bits_i,
  input wire logic key_irq_mask_i,
  input wire logic key_level_sense_select_i,
  input wire logic key_irq_acknowledge_i,
  // CPU side
  input wire logic vector_fetch_i,
  output logic irq_o,
  output logic [15:0] vector_addr_hi_o,
  output logic [15:0] vector_addr_lo_o,
  // Status
  output logic key_pending_flag_o,
  output logic key_irq_acknowledge_o,
  output logic [N-1:0] pin_irq_enable_bits_o,
  output logic key_irq_mask_o,
  output logic key_level_sense_select_o
);
  kpil_pin_if #(.N(N)) pins ();

  logic [N-1:0] enable;
  logic mask;
  logic mode;
  logic [N-1:0] next_enable;
  logic next_mask;
  logic next_mode;
  kpil_pkg::kpil_state_e state;
  kpil_pkg::kpil_state_e next_state;
  logic acked;
  logic next_acked;
  logic irq;
  logic next_irq;
  logic any_low;
  logic fall;
  logic ack;

  // ---------------------------------------------------------------
  // Pin stage
  // ---------------------------------------------------------------
  kpil_pin_sync #(.N(N)) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(key_pin_i),
    .sync(pins.src)
  );

  kpil_edge_det #(.N(N)) u_edge (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .enable_i(enable),
    .sync(pins.dst),
    .any_low_o(any_low),
    .fall_o(fall)
  );

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  always_comb begin
    next_enable = enable;
    next_mask = mask;
    next_mode = mode;
    if (ctrl_we_i) begin
      next_enable = pin_irq_enable_bits_i; // see R1
      next_mask = key_irq_mask_i; // see R2
      next_mode = key_level_sense_select_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enable <= `KPIL_RST_ENABLE; // see R21
      mask <= `KPIL_RST_MASK; // see R20
      mode <= `KPIL_RST_MODE; // see R13
    end else begin
      enable <= next_enable;
      mask <= next_mask;
      mode <= next_mode;
    end
  end

  // Acknowledge pulse only from a write of 1 or a vector fetch
  assign ack = vector_fetch_i | (ctrl_we_i & key_irq_acknowledge_i); // see R8 see R9

  // ---------------------------------------------------------------
  // Request latch
  // ---------------------------------------------------------------
  // New fall wins over a same-cycle acknowledge so no event is lost.
  always_comb begin
    next_state = state;
    next_acked = acked;
    case (state)
      kpil_pkg::KPIL_IDLE: begin
        next_acked = 1'b0;
        if (fall) begin
          next_state = kpil_pkg::KPIL_HELD; // see R4
        end
      end
      kpil_pkg::KPIL_HELD: begin
        if (fall) begin
          next_acked = 1'b0; // see R10
        end else if (!mode) begin
          if (ack) begin
            next_state = kpil_pkg::KPIL_IDLE; // see R12
          end
        end else begin
          // Level mode needs ack and all-high, in any order
          if (ack || acked) begin
            if (!any_low) begin
              next_state = kpil_pkg::KPIL_IDLE; // see R7
              next_acked = 1'b0;
            end else begin
              next_acked = 1'b1; // see R6
            end
          end
        end
      end
      default: begin
        next_state = kpil_pkg::KPIL_IDLE;
        next_acked = 1'b0;
      end
    endcase
    // Mode cleared while only waiting on level: edge rules apply
    next_irq = (next_state == kpil_pkg::KPIL_HELD) & ~next_mask; // see R11 see R20
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= kpil_pkg::KPIL_IDLE; // see R13
      acked <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      acked <= next_acked;
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign irq_o = irq;
  assign vector_addr_hi_o = `KPIL_VEC_HI; // see R11
  assign vector_addr_lo_o = `KPIL_VEC_LO;
  assign key_pending_flag_o = (state == kpil_pkg::KPIL_HELD); // see R14
  assign key_irq_acknowledge_o = 1'b0; // see R19
  assign pin_irq_enable_bits_o = enable;
  assign key_irq_mask_o = mask;
  assign key_level_sense_select_o = mode;
  assign key_pullup_en_o = enable; // see R3
  assign key_force_input_o = enable; // see R15
  assign key_read_ok_o = ~port_a_direction_bits_i; // see R15
endmodule

/* File: src/kpil_params.svh */
// Purpose: Constants for the keypad pin interrupt latch.
// Assumes: 25 MHz bus clock, synchronous active-high reset.
// Notes: Rule summary follows.
// Operation
// R1: Five key pins, each with its own interrupt enable bit.
// R2: One shared mask gates all five pins; enables stay per pin.
// R3: Enabling a pin's interrupt also turns on its pullup.
// R4: Latch request when enabled pins go low after all were high.
// R5: Edge-only mode ignores a fall while another enabled pin is low.
// R6: Edge-plus-level mode keeps request while any enabled pin is low.
// R7: Level mode clears only after acknowledge and all pins high, any order.
// R8: Vector fetch acknowledges and clears the latched request.
// R9: Writing 1 to acknowledge clears the request like a vector fetch.
// R10: Acknowledge leaves later edges alone; a later fall latches again.
// R11: With mask clear, pending request goes to CPU, vector FFE4/FFE5.
// R12: Edge mode: acknowledge clears the request at once.
// R13: Reset clears the latch and the mode even with a pin low.
// R14: Pending flag ignores the mask so software can poll.
// R15: Enable forces pin to input; pin readable only with direction 0.
// R16: Software masks, enables, acknowledges, then unmasks.
// R17: Software delays acknowledge of level pins by load-dependent time.
// R18: Software may drive pins high as outputs before enabling.
// R19: Acknowledge is write-only, reads 0, cleared by reset.
// R20: Mask set blocks the CPU interrupt; reset clears the mask.
// R21: Reset clears every pin interrupt enable.
// R22: Pins are synchronised; falls detected against previous all-high.
`ifndef KPIL_PARAMS_SVH
`define KPIL_PARAMS_SVH
`define KPIL_NUM_PINS 5
`define KPIL_VEC_HI 16'hFFE4
`define KPIL_VEC_LO 16'hFFE5
`define KPIL_RST_ENABLE 5'h00
`define KPIL_RST_MASK 1'h0
`define KPIL_RST_MODE 1'h0
`endif

/* File: src/kpil_pkg.sv */
// Purpose: Types for the keypad pin interrupt latch.
// Assumes: Nothing beyond the params header.
// Notes: Request state machine states.
package kpil_pkg;
  typedef enum logic [1:0] {
    KPIL_IDLE = 2'h1,
    KPIL_HELD = 2'h2
  } kpil_state_e;
endpackage

/* File: src/kpil_pin_if.sv */
// Purpose: Carries synchronised pin levels between pin stage and core.
// Assumes: Single clock domain.
// Notes: Width follows the pin count.
`timescale 1ns/1ps
interface kpil_pin_if #(parameter int N = 5);
  logic [N-1:0] level;
  logic [N-1:0] stable;
  modport src (output level, output stable);
  modport dst (input level, input stable);
endinterface

/* File: src/kpil_pin_sync.sv */
// Purpose: Three-flop synchroniser for the key pins.
// Assumes: Pins are asynchronous to clk_i.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/1ps
module kpil_pin_sync #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Raw pins
  input wire logic [N-1:0] pin_i,
  // Synchronised result
  kpil_pin_if.src sync
);
  logic [N-1:0] s1, s2, s3, lvl;
  logic [N-1:0] next_s1, next_s2, next_s3, next_lvl;

  always_comb begin
    next_s1 = pin_i;
    next_s2 = s1;
    next_s3 = s2;
    // Only update where the two late stages agree
    next_lvl = (s2 & s3) | (lvl & (s2 | s3));
  end

  // Pullups idle high, so reset to all-high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= {N{1'b1}};
      s2 <= {N{1'b1}};
      s3 <= {N{1'b1}};
      lvl <= {N{1'b1}};
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      lvl <= next_lvl;
    end
  end

  assign sync.level = lvl;
  assign sync.stable = ~(s2 ^ s3);
endmodule

/* File: src/kpil_edge_det.sv */
// Purpose: Detects the all-high to some-low event over enabled pins.
// Assumes: Levels already synchronised.
// Notes: Disabled pins read as high so they never block or trigger.
`timescale 1ns/1ps
module kpil_edge_det #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Inputs
  input wire logic [N-1:0] enable_i,
  kpil_pin_if.dst sync,
  // Outputs
  output logic any_low_o,
  output logic fall_o
);
  logic prev_all_high;
  logic next_prev_all_high;

  function automatic logic any_low_f(input logic [N-1:0] lv, input logic [N-1:0] en);
    any_low_f = |(~lv & en);
  endfunction

  assign any_low_o = any_low_f(sync.level, enable_i);

  always_comb begin
    next_prev_all_high = ~any_low_o;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_all_high <= 1'b1;
    end else begin
      prev_all_high <= next_prev_all_high;
    end
  end

  // A fall only counts after every enabled pin was high  see R4 see R5 see R22
  assign fall_o = prev_all_high & any_low_o;
endmodule

/* File: verif/kpil_props.sv */
// Purpose: Port checks for the keypad pin interrupt latch.
// Assumes: Bound to kpil_top; one clock.
// Notes: Press windows exclude writes and fetches.
`timescale 1ns/1ps
module kpil_props #(parameter int N = 5) (
  // Clock and inputs
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [N-1:0] key_pin_i,
  input wire logic ctrl_we_i,
  input wire logic vector_fetch_i,
  // Outputs
  input wire logic [N-1:0] key_pullup_en_o,
  input wire logic [N-1:0] key_force_input_o,
  input wire logic irq_o,
  input wire logic [15:0] vector_addr_hi_o,
  input wire logic key_pending_flag_o,
  input wire logic key_irq_acknowledge_o,
  input wire logic [N-1:0] pin_irq_enable_bits_o,
  input wire logic key_irq_mask_o,
  input wire logic key_level_sense_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic en_low;
  logic [N-1:0] seen;
  assign en_low = |(~key_pin_i & pin_irq_enable_bits_o);
  // Disabled pins float, so they are masked out of stability
  assign seen = key_pin_i | ~pin_irq_enable_bits_o;
  sequence s_quiet_high; (!en_low && !ctrl_we_i)[*4]; endsequence
  sequence s_press; (en_low && !ctrl_we_i && !vector_fetch_i)[*6]; endsequence
  // Six steady cycles cover the three sync flops plus the agree stage
  sequence s_steady; $stable(seen)[*6]; endsequence
  a_pullup_force: assert property (key_pullup_en_o == pin_irq_enable_bits_o
    && key_force_input_o == pin_irq_enable_bits_o) else $error("pullup or input force wrong");
  a_ack_zero: assert property (!key_irq_acknowledge_o) else $error("ack reads 1");
  a_vector_fixed: assert property (vector_addr_hi_o == 16'hFFE4)
    else $error("vector address wrong");
  a_irq_gate: assert property (irq_o == (key_pending_flag_o && !key_irq_mask_o))
    else $error("irq not pending and unmasked");
  a_reset_clear: assert property ($fell(srst_i) |-> !key_pending_flag_o && !irq_o
    && pin_irq_enable_bits_o == '0 && !key_level_sense_select_o) else $error("reset state");
  a_fall_latch: assert property (s_quiet_high ##1 s_press |-> key_pending_flag_o)
    else $error("fall not latched");
  a_edge_clear: assert property (s_steady ##0 (vector_fetch_i && !ctrl_we_i
    && !key_level_sense_select_o) |=> !key_pending_flag_o) else $error("edge ack kept");
  a_level_hold: assert property (s_steady ##0 (en_low && key_pending_flag_o && !ctrl_we_i
    && key_level_sense_select_o) |=> key_pending_flag_o) else $error("level request lost");
endmodule

/* File: verif/kpil_keys.sv */
// Purpose: Keys pulling pins low, with pullups.
// Assumes: One press bit per pin.
// Notes: Unpulled open pins toggle every cycle.
`timescale 1ns/1ps
module kpil_keys #(parameter int N = 5) (
  // Clock and controls
  input wire logic clk_i,
  input wire logic [N-1:0] press_i,
  input wire logic [N-1:0] pullup_en_i,
  // Port output bits, data held at 1
  input wire logic [N-1:0] drive_hi_i,
  // Pins
  output logic [N-1:0] pin_o
);
  logic [N-1:0] wander = '0;
  always @(posedge clk_i) wander <= ~wander;
  // A pressed key overpowers the port driver
  assign pin_o = ~press_i & (pullup_en_i | drive_hi_i | wander);
endmodule

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the keypad pin interrupt latch.
// Assumes: Inputs driven at the falling edge.
// Notes: Random phase uses xorshift from 23874.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic we = 1'b0;
  logic vf = 1'b0;
  logic mask = 1'b0;
  logic mode = 1'b0;
  logic ack = 1'b0;
  logic [4:0] en = 5'h00;
  logic [4:0] press = 5'h00;
  logic [4:0] dir = 5'h00;
  logic [4:0] pin, pu, fi, rok, en_o;
  logic irq, pend, ack_o, mask_o, mode_o;
  logic [15:0] vhi, vlo;
  logic [31:0] seed = 32'h00005D42;
  int failures = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  kpil_keys keys (.clk_i(clk), .press_i(press), .pullup_en_i(pu), .drive_hi_i(dir),
    .pin_o(pin));
  kpil_top dut (.clk_i(clk), .srst_i(srst), .key_pin_i(pin), .key_pullup_en_o(pu),
    .key_force_input_o(fi), .key_read_ok_o(rok), .port_a_direction_bits_i(dir),
    .ctrl_we_i(we), .pin_irq_enable_bits_i(en), .key_irq_mask_i(mask),
    .key_level_sense_select_i(mode), .key_irq_acknowledge_i(ack), .vector_fetch_i(vf),
    .irq_o(irq), .vector_addr_hi_o(vhi), .vector_addr_lo_o(vlo), .key_pending_flag_o(pend),
    .key_irq_acknowledge_o(ack_o), .pin_irq_enable_bits_o(en_o), .key_irq_mask_o(mask_o),
    .key_level_sense_select_o(mode_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
  // CPU request is the pending flag gated by the mask
  function automatic logic exp_irq(input logic p, input logic m);
    return p & ~m;
  endfunction
  task automatic test_done();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] e, input logic m, input logic md, input logic a);
    {en, mask, mode, ack, we} = {e, m, md, a, 1'b1};
    cyc(1);
    {ack, we} = 2'b00;
    cyc(1);
  endtask
  task automatic fetch(); vf = 1'b1; cyc(1); vf = 1'b0; endtask
  task automatic wp(input logic v, input string m);
    int i;
    i = 0;
    while (pend !== v && i < 20) begin cyc(1); i++; end
    chk(pend === v, m);
    if (pend !== v) test_done();
  endtask
  initial begin
    cyc(3);
    srst = 1'b0;
    cyc(1);
    chk(en_o === 5'h00 && mask_o === 1'b0 && mode_o === 1'b0 && pend === 1'b0, "reset");
    dir = 5'h1F;
    wr(5'h00, 1, 0, 0);
    wr(5'h1F, 1, 0, 0);
    dir = 5'h0A;
    wr(5'h1F, 1, 0, 1);
    chk(pu === 5'h1F && fi === 5'h1F && rok === ~dir, "pin setup");
    chk(en_o === 5'h1F && mask_o === 1'b1, "enable readback");
    press = 5'h01;
    wp(1, "masked latch");
    chk(irq === 1'b0, "masked irq");
    wr(5'h1F, 0, 0, 0);
    cyc(1);
    chk(irq === 1'b1 && vhi === 16'hFFE4 && vlo === 16'hFFE5, "irq out");
    fetch();
    wp(0, "fetch clear");
    press = 5'h03;
    cyc(8);
    chk(pend === 1'b0, "fall while low");
    press = 5'h00;
    cyc(6);
    press = 5'h04;
    wp(1, "new fall");
    wr(5'h1F, 0, 0, 1);
    wp(0, "soft ack");
    press = 5'h00;
    wr(5'h1E, 0, 0, 0);
    cyc(4);
    press = 5'h01;
    cyc(8);
    chk(pend === 1'b0, "disabled pin");
    press = 5'h00;
    // Re-enabled pin may read low until its pullup settles
    wr(5'h1F, 1, 1, 0);
    cyc(4);
    wr(5'h1F, 1, 1, 1);
    wr(5'h1F, 0, 1, 0);
    cyc(4);
    press = 5'h08;
    wp(1, "level latch");
    fetch();
    cyc(4);
    chk(pend === 1'b1, "level held");
    press = 5'h00;
    wp(0, "level clear");
    press = 5'h10;
    wp(1, "level latch 2");
    press = 5'h00;
    cyc(8);
    chk(pend === 1'b1, "waits ack");
    wr(5'h1F, 0, 1, 1);
    wp(0, "ack last");
    press = 5'h02;
    wp(1, "pre reset");
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    chk(pend === 1'b0 && mode_o === 1'b0, "reset with pin low");
    for (int k = 0; k < 60; k++) begin
      seed = xs(seed);
      press = seed[4:0];
      dir = seed[9:5];
      if (seed[12]) fetch();
      if (seed[15:13] < 3'h2) wr(seed[20:16], seed[21], seed[22], seed[23]);
      cyc(6);
      chk(rok === ~dir && irq === exp_irq(pend, mask_o), "random");
      chk(ack_o === 1'b0, "ack reads zero");
    end
    test_done();
  end
endmodule
bind kpil_top kpil_props #(.N(N)) u_props (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .key_pin_i(key_pin_i),
  .ctrl_we_i(ctrl_we_i),
  .vector_fetch_i(vector_fetch_i),
  .key_pullup_en_o(key_pullup_en_o),
  .key_force_input_o(key_force_input_o),
  .irq_o(irq_o),
  .vector_addr_hi_o(vector_addr_hi_o),
  .key_pending_flag_o(key_pending_flag_o),
  .key_irq_acknowledge_o(key_irq_acknowledge_o),
  .pin_irq_enable_bits_o(pin_irq_enable_bits_o),
  .key_irq_mask_o(key_irq_mask_o),
  .key_level_sense_select_o(key_level_sense_select_o)
);
